// [src/sbsc_top.sv]
// Purpose: Control core of a synchronous burst SRAM with flip-flop storage
// Assumes: Command pins sampled on the rising edge of i_clock; output enable, sleep and strap pins act without a clock
// Notes: Writes pass through a queue before reaching the array
// Operation
// - Two low address bits preset burst counter
// - One active-low write enable per lane
// - Byte write writes all enabled lanes
// - Global write writes every lane
// - Three chip enables, middle one active high
// - Active-low advance input steps the burst
// - Processor or cache strobe loads external address
// - Sleep high means standby, low means run
// - Burst order strap: low linear, high interleaved
// - Output strap: low flow-through, high pipelined
// - Deselect strap: low dual, high single cycle
// - Ninth-bit strap low enables parity lanes
// - Open output, deselect, drive and sleep pins take their pull default levels
// - Linear order counts up modulo four
// - Interleaved order XORs start with index
// - Byte write without lanes selected reads
// - Pipelined reads pass an extra output register
// - Dual deselect turns pipelined outputs off one later
`timescale 1ns/1ns
module sbsc_top #(
    parameter int LANES = sbsc_pkg::LANES,
    parameter int ADDR_W = sbsc_pkg::ADDR_W,
    parameter int FIFO_DEPTH = sbsc_pkg::FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [ADDR_W-3:0] i_addr_high,
    input wire logic i_addr_lsb_zero,
    input wire logic i_addr_lsb_one,
    input wire logic [LANES-1:0] i_lane_write_n,
    input wire logic i_byte_write_n,
    input wire logic i_global_write_n,
    input wire logic i_chip_select_one_n,
    input wire logic i_chip_select_two,
    input wire logic i_chip_select_three_n,
    input wire logic i_burst_step_n,
    input wire logic i_proc_addr_strobe_n,
    input wire logic i_cache_addr_strobe_n,
    input wire logic i_output_enable_n,
    input wire logic i_sleep_request,
    input wire logic i_linear_order_n,
    input wire logic i_flow_through_n,
    input wire logic i_deselect_mode_sel,
    input wire logic i_ninth_bit_on_n,
    input wire logic i_drive_strength_sel,
    input wire logic [sbsc_pkg::OPEN_W-1:0] i_strap_open,
    input wire logic [LANES*sbsc_pkg::LANE_BITS-1:0] i_dq,
    output logic [LANES*sbsc_pkg::LANE_BITS-1:0] o_dq,
    output logic [LANES*sbsc_pkg::LANE_BITS-1:0] o_dq_oe,
    output logic [sbsc_pkg::BURST_W-1:0] o_burst_addr,
    output logic o_write_ready,
    output logic o_sleeping,
    output logic o_high_drive
);
    localparam int LB = sbsc_pkg::LANE_BITS;
    localparam int DW = LANES * LB;
    localparam int QW = ADDR_W + DW + LANES;
    localparam int DEPTH = 1 << ADDR_W;

    sbsc_pkg::sbsc_state_t state;
    sbsc_pkg::sbsc_state_t next_state;
    logic [sbsc_pkg::BURST_W-1:0] count;
    logic [sbsc_pkg::BURST_W-1:0] next_count;
    logic [sbsc_pkg::BURST_W-1:0] start_low;
    logic [ADDR_W-3:0] base_high;
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] q_first;
    logic [DW-1:0] q_second;
    logic v_first;
    logic v_second;
    logic desel_first;

    sbsc_stream_if #(.WIDTH(QW)) push_if ();
    sbsc_stream_if #(.WIDTH(QW)) pop_if ();

    // Effective strap levels
    wire logic flow_strap = i_strap_open[sbsc_pkg::OPEN_FLOW]
        ? sbsc_pkg::FLOW_DEFAULT : i_flow_through_n;
    wire logic desel_strap = i_strap_open[sbsc_pkg::OPEN_DESELECT]
        ? sbsc_pkg::DESELECT_DEFAULT : i_deselect_mode_sel;
    wire logic drive_strap = i_strap_open[sbsc_pkg::OPEN_DRIVE]
        ? sbsc_pkg::DRIVE_DEFAULT : i_drive_strength_sel;
    wire logic sleep_level = i_strap_open[sbsc_pkg::OPEN_SLEEP]
        ? sbsc_pkg::SLEEP_DEFAULT : i_sleep_request;
    wire logic pipelined = flow_strap;
    wire logic single_deselect = desel_strap;
    wire logic linear = ~i_linear_order_n;
    wire logic parity_on = ~i_ninth_bit_on_n;
    wire logic awake = ~sleep_level;

    // Command decode
    wire logic selected = ~i_chip_select_one_n & i_chip_select_two
        & ~i_chip_select_three_n;
    wire logic proc_start = awake & selected & ~i_proc_addr_strobe_n;
    wire logic cache_start = awake & selected & i_proc_addr_strobe_n
        & ~i_cache_addr_strobe_n;
    wire logic deselect = awake & ~selected & ~i_cache_addr_strobe_n;
    wire logic start_any = proc_start | cache_start;
    wire logic cont = awake & ~start_any & ~deselect
        & i_cache_addr_strobe_n & (state == sbsc_pkg::ST_BURST);
    wire logic step = cont & ~i_burst_step_n;

    // Lane write mask
    wire logic [LANES-1:0] byte_mask = i_byte_write_n ? '0 : ~i_lane_write_n;
    wire logic [LANES-1:0] lane_mask = ~i_global_write_n ? '1 : byte_mask;
    wire logic is_write = |lane_mask;
    wire logic write_cyc = (cache_start | cont) & is_write;
    wire logic read_cyc = proc_start | ((cache_start | cont) & ~is_write);

    // Burst address generation
    wire logic [sbsc_pkg::BURST_W-1:0] ext_low = {i_addr_lsb_one, i_addr_lsb_zero};
    wire logic [sbsc_pkg::BURST_W-1:0] use_low = start_any ? ext_low : start_low;
    wire logic [sbsc_pkg::BURST_W-1:0] lin_low = use_low + next_count;
    wire logic [sbsc_pkg::BURST_W-1:0] ilv_low = use_low ^ next_count;
    wire logic [sbsc_pkg::BURST_W-1:0] order_low = linear ? lin_low : ilv_low;
    wire logic [ADDR_W-3:0] use_high = start_any ? i_addr_high : base_high;
    wire logic [ADDR_W-1:0] cur_addr = {use_high, order_low};
    wire logic [DW-1:0] rd_word = mem[cur_addr];

    // Write data with parity bits cleared when parity lanes are off
    logic [DW-1:0] wr_data;
    logic [DW-1:0] oe_mask;
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            assign wr_data[g*LB +: LB-1] = i_dq[g*LB +: LB-1];
            assign wr_data[g*LB+LB-1] = i_dq[g*LB+LB-1] & parity_on;
            assign oe_mask[g*LB +: LB-1] = '1;
            assign oe_mask[g*LB+LB-1] = parity_on;
        end
    endgenerate

    // Queue drains only in cycles without an array read
    assign push_if.valid = write_cyc;
    assign push_if.data = {cur_addr, wr_data, lane_mask};
    assign pop_if.ready = ~read_cyc;
    wire logic drain = pop_if.valid & pop_if.ready;
    wire logic [ADDR_W-1:0] drain_addr = pop_if.data[QW-1 -: ADDR_W];
    wire logic [DW-1:0] drain_data = pop_if.data[LANES +: DW];
    wire logic [LANES-1:0] drain_mask = pop_if.data[LANES-1:0];

    sbsc_fifo #(
        .WIDTH(QW),
        .DEPTH(FIFO_DEPTH)
    ) u_write_queue (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .s_in(push_if),
        .s_out(pop_if)
    );

    // Lane merge, so the array has a single writer
    logic [DW-1:0] drain_word;
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_store
            assign drain_word[g*LB +: LB] = drain_mask[g] ? drain_data[g*LB +: LB]
                : mem[drain_addr][g*LB +: LB];
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (drain) begin
            mem[drain_addr] <= drain_word;
        end
    end

    // Burst state and counter
    always_comb begin
        next_state = state;
        next_count = count;
        if (start_any) begin
            next_state = sbsc_pkg::ST_BURST;
            next_count = sbsc_pkg::BURST_RESET;
        end else if (deselect) begin
            next_state = sbsc_pkg::ST_IDLE;
        end else if (step) begin
            next_count = count + sbsc_pkg::BURST_ONE;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state <= sbsc_pkg::ST_IDLE;
            count <= sbsc_pkg::BURST_RESET;
            start_low <= sbsc_pkg::BURST_RESET;
            base_high <= '0;
            o_burst_addr <= sbsc_pkg::BURST_RESET;
        end else begin
            state <= next_state;
            count <= next_count;
            if (start_any) begin
                start_low <= ext_low;
                base_high <= i_addr_high;
            end
            if (start_any || cont) begin
                o_burst_addr <= order_low;
            end
        end
    end

    // Read pipeline
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            q_first <= '0;
            q_second <= '0;
            v_first <= 1'b0;
            v_second <= 1'b0;
            desel_first <= 1'b0;
        end else begin
            if (read_cyc) begin
                q_first <= rd_word;
            end
            q_second <= q_first;
            v_first <= read_cyc;
            v_second <= v_first;
            desel_first <= deselect | ~awake;
        end
    end

    // Output drive
    wire logic pipe_on = single_deselect ? (v_second & ~desel_first) : v_second;
    wire logic read_on = pipelined ? pipe_on : v_first;
    wire logic drive_on = read_on & ~i_output_enable_n & awake;

    assign o_dq = pipelined ? q_second : q_first;
    assign o_dq_oe = drive_on ? oe_mask : '0;
    assign o_write_ready = push_if.ready;
    assign o_sleeping = sleep_level;
    assign o_high_drive = ~drive_strap;
endmodule

// [src/sbsc_pkg.sv]
// Purpose: Shared constants and types for the synchronous burst SRAM control block
// Assumes: One 125 MHz clock, synchronous active-high reset
// Notes: Strap default levels model the pad pull devices
package sbsc_pkg;
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int LANES = 4;
    localparam int LANE_BITS = 9;
    localparam int ADDR_W = 6;
    localparam int FIFO_DEPTH = 16;
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_RESET = 2'h0;
    localparam logic [1:0] BURST_ONE = 2'h1;
    // Levels a strap takes when its pin is left open
    localparam logic FLOW_DEFAULT = 1'h1;
    localparam logic DESELECT_DEFAULT = 1'h1;
    localparam logic DRIVE_DEFAULT = 1'h1;
    localparam logic SLEEP_DEFAULT = 1'h0;
    // Bit positions in the open-pin indicator vector
    localparam int OPEN_FLOW = 0;
    localparam int OPEN_DESELECT = 1;
    localparam int OPEN_DRIVE = 2;
    localparam int OPEN_SLEEP = 3;
    localparam int OPEN_W = 4;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BURST = 1'b1
    } sbsc_state_t;
endpackage

// [src/sbsc_stream_if.sv]
// Purpose: Valid/ready word carrier between the control block and its write queue
// Assumes: Transfer when valid and ready are both high at a clock edge
// Notes: Width is a parameter
`timescale 1ns/1ns
interface sbsc_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// [src/sbsc_fifo.sv]
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Full and empty from pointers with a wrap bit
`timescale 1ns/1ns
module sbsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = sbsc_pkg::FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    sbsc_stream_if.snk s_in,
    sbsc_stream_if.src s_out
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W:0] wr_ptr;
    logic [PTR_W:0] rd_ptr;
    wire logic empty = (wr_ptr == rd_ptr);
    wire logic full = (wr_ptr[PTR_W] != rd_ptr[PTR_W])
        && (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
    wire logic do_push = s_in.valid & ~full;
    wire logic do_pop = s_out.ready & ~empty;

    assign s_in.ready = ~full;
    assign s_out.valid = ~empty;
    assign s_out.data = store[rd_ptr[PTR_W-1:0]];

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (do_push) begin
            store[wr_ptr[PTR_W-1:0]] <= s_in.data;
        end
    end
endmodule

// [tb/sbsc_checker_asserts.sv]
// Purpose: Port-level assertions for the burst SRAM control block
// Assumes: Only top-level ports are visible
// Notes: Helper logic rebuilds the expected burst address
`timescale 1ns/1ns
module sbsc_checker #(parameter int LANES = sbsc_pkg::LANES) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_addr_lsb_zero,
    input wire logic i_addr_lsb_one,
    input wire logic i_chip_select_one_n,
    input wire logic i_chip_select_two,
    input wire logic i_chip_select_three_n,
    input wire logic i_burst_step_n,
    input wire logic i_proc_addr_strobe_n,
    input wire logic i_cache_addr_strobe_n,
    input wire logic i_output_enable_n,
    input wire logic i_sleep_request,
    input wire logic i_linear_order_n,
    input wire logic i_flow_through_n,
    input wire logic i_deselect_mode_sel,
    input wire logic i_ninth_bit_on_n,
    input wire logic i_drive_strength_sel,
    input wire logic [sbsc_pkg::OPEN_W-1:0] i_strap_open,
    input wire logic [LANES*sbsc_pkg::LANE_BITS-1:0] o_dq_oe,
    input wire logic [sbsc_pkg::BURST_W-1:0] o_burst_addr,
    input wire logic o_sleeping,
    input wire logic o_high_drive
);
    logic in_burst;
    logic lin;
    logic [1:0] start;
    logic [1:0] idx;
    wire logic en = !i_chip_select_one_n && i_chip_select_two && !i_chip_select_three_n;
    wire logic sel = en && !o_sleeping;
    wire logic go = sel && (!i_proc_addr_strobe_n || !i_cache_addr_strobe_n);
    wire logic rd = sel && !i_proc_addr_strobe_n;
    wire logic desel = !o_sleeping && !en && !i_cache_addr_strobe_n;
    wire logic cont = !o_sleeping && i_cache_addr_strobe_n && (i_proc_addr_strobe_n || !en);
    wire logic ft = i_flow_through_n || i_strap_open[0];
    wire logic dm = i_deselect_mode_sel || i_strap_open[1];
    wire logic [1:0] want = lin ? start + idx : start ^ idx;
    wire logic shown = i_output_enable_n || o_sleeping || o_dq_oe[7:0] == 8'hff;
    always_ff @(posedge i_clock) begin
        in_burst <= !(i_sys_rst || desel) && (go || in_burst);
        if (go) begin
            start <= {i_addr_lsb_one, i_addr_lsb_zero};
            idx <= 2'h0;
            lin <= !i_linear_order_n;
        end else if (cont && in_burst && !i_burst_step_n) begin
            idx <= idx + 2'h1;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    a_burst_seq: assert property (in_burst |-> o_burst_addr == want)
        else $error("burst address off sequence");
    a_sleep_quiet: assert property (o_sleeping |-> o_dq_oe == '0)
        else $error("drive while sleeping");
    a_sleep_level: assert property (o_sleeping == (i_sleep_request && !i_strap_open[3]))
        else $error("sleep level wrong");
    a_drive_level: assert property (o_high_drive == !(i_drive_strength_sel || i_strap_open[2]))
        else $error("drive strap wrong");
    a_flow_read: assert property (rd && !ft |-> ##1 shown)
        else $error("flow read late");
    a_pipe_read: assert property (rd && ft ##1 !desel |-> ##1 shown)
        else $error("pipelined read late");
    a_dual_hold: assert property (rd && ft && !dm ##1 desel |=> shown)
        else $error("dual deselect cut read early");
    a_single_cut: assert property (rd && ft && dm ##1 desel |=> o_dq_oe == '0)
        else $error("single deselect kept drive");
    a_parity_off: assert property (i_ninth_bit_on_n [*4] |-> o_dq_oe[8] == 1'b0)
        else $error("parity bit driven");
    a_dual_desel: assert property (desel && !dm ##1 cont [*2] |=> o_dq_oe == '0)
        else $error("dual deselect drive");
    a_single_desel: assert property (desel && dm ##1 cont |=> o_dq_oe == '0)
        else $error("single deselect drive");
    c_flow: cover property (rd && !ft);
    c_wrap: cover property (in_burst && idx == 2'h3);
    c_dual: cover property (desel && !dm);
endmodule
bind sbsc_top sbsc_checker #(.LANES(LANES)) chk_u (.*);

// [tb/sbsc_host_model.sv]
// Purpose: Processor or cache controller issuing memory commands
// Assumes: Commands change just after the rising edge
// Notes: Released data lines show the inverse of the last word
`timescale 1ns/1ns
module sbsc_host_model (
    input wire logic i_clock,
    output logic [5:0] o_addr,
    output logic [3:0] o_lane_n,
    output logic o_bw_n,
    output logic o_gw_n,
    output logic [2:0] o_sel,
    output logic o_step_n,
    output logic o_proc_n,
    output logic o_cache_n,
    output logic [35:0] o_dq
);
    // Kind 0 continue, 1 processor read, 2 cache start, 3 deselect
    task automatic cyc(input int k, input logic st, input logic [5:0] a, input logic [3:0] m,
                       input logic [35:0] d, input logic [2:0] s);
        @(posedge i_clock);
        #1;
        o_addr = a;
        o_sel = s;
        o_proc_n = (k != 1);
        o_cache_n = (k < 2);
        o_step_n = !st;
        o_gw_n = (m != 4'hf);
        o_bw_n = (m == 4'h0);
        o_lane_n = (m == 4'hf) ? d[3:0] : ~m;
        o_dq = (m != 4'h0) ? d : ~o_dq;
    endtask
    initial begin
        o_addr = 6'h0;
        o_lane_n = 4'hf;
        o_bw_n = 1'b1;
        o_gw_n = 1'b1;
        o_sel = 3'b101;
        o_step_n = 1'b1;
        o_proc_n = 1'b1;
        o_cache_n = 1'b1;
        o_dq = 36'h0;
    end
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the burst SRAM control block
// Assumes: Straps stay steady within a burst
// Notes: Shadow memory predicts every read
`timescale 1ns/1ns
module tb_top;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_output_enable_n = 1'b0, i_sleep_request = 1'b0, i_drive_strength_sel = 1'b1;
    logic i_linear_order_n = 1'b0, i_flow_through_n = 1'b0, i_deselect_mode_sel = 1'b0;
    logic i_ninth_bit_on_n = 1'b0;
    logic [3:0] i_strap_open = 4'h0;
    logic [5:0] addr;
    logic [2:0] sel;
    wire logic [3:0] i_addr_high;
    wire logic i_addr_lsb_zero, i_addr_lsb_one;
    wire logic i_chip_select_one_n, i_chip_select_two, i_chip_select_three_n;
    logic [3:0] i_lane_write_n;
    logic i_byte_write_n, i_global_write_n, i_burst_step_n;
    logic i_proc_addr_strobe_n, i_cache_addr_strobe_n;
    logic [35:0] i_dq, o_dq, o_dq_oe;
    logic [1:0] o_burst_addr;
    logic o_write_ready, o_sleeping, o_high_drive;
    logic [35:0] mem [64];
    logic [31:0] seed = 32'h42ad3827;
    int errors = 0, num_checks = 0, cycles = 0;
    assign {i_addr_high, i_addr_lsb_one, i_addr_lsb_zero} = addr;
    assign {i_chip_select_one_n, i_chip_select_two, i_chip_select_three_n} = sel;
    sbsc_top dut_u (.*);
    sbsc_host_model host_u (.i_clock(i_clock), .o_addr(addr), .o_lane_n(i_lane_write_n),
        .o_bw_n(i_byte_write_n), .o_gw_n(i_global_write_n), .o_sel(sel),
        .o_step_n(i_burst_step_n), .o_proc_n(i_proc_addr_strobe_n),
        .o_cache_n(i_cache_addr_strobe_n), .o_dq(i_dq));
    initial begin
        forever #4 i_clock = ~i_clock;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [5:0] at(logic [5:0] a, int i, logic lin_n);
        return {a[5:2], lin_n ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)};
    endfunction
    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] d, logic [3:0] m, logic p);
        for (int g = 0; g < 4; g++) begin
            if (m[g] || m == 4'hf) begin
                o[9*g +: 9] = {d[9*g+8] & !p, d[9*g +: 8]};
            end
        end
        return o;
    endfunction
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("unexpected at %0t: timeout", $time);
            print_verdict();
        end
    end
    initial begin
        logic [5:0] a;
        logic [3:0] m;
        logic [35:0] d;
        logic [5:0] wa;
        logic ft;
        logic sd;
        repeat (3) @(posedge i_clock);
        #1 i_sys_rst = 1'b0;
        for (int i = 0; i < 64; i++) begin
            d = 36'({rnd(), rnd()});
            mem[i] = merge(mem[i], d, 4'hf, 1'b0);
            host_u.cyc(2, 0, 6'(i), 4'hf, d, 3'b010);
            host_u.cyc(3, 0, 6'(i), 4'h0, d, 3'b000);
        end
        $display("preload done");
        for (int md = 0; md < 9; md++) begin
            {i_ninth_bit_on_n, i_deselect_mode_sel, i_flow_through_n, i_linear_order_n} = 4'(md);
            i_strap_open = (md == 8) ? 4'h3 : 4'h0;
            ft = i_flow_through_n | i_strap_open[0];
            sd = i_deselect_mode_sel | i_strap_open[1];
            a = 6'(rnd());
            m = (md == 1) ? 4'h0 : (md == 2) ? 4'hf : 4'(rnd());
            for (int i = 0; i < 5; i++) begin
                d = 36'({rnd(), rnd()});
                wa = at(a, i, i_linear_order_n);
                mem[wa] = merge(mem[wa], d, m, i_ninth_bit_on_n);
                host_u.cyc(i == 0 ? 2 : 0, i != 0, a, m, d, 3'b010);
            end
            host_u.cyc(3, 0, a, 4'h0, d, 3'b010 ^ (3'b001 << (md % 3)));
            repeat (20) host_u.cyc(0, 0, a, 4'h0, d, 3'b010);
            for (int i = 0; i < 4; i++) begin
                host_u.cyc(1, 0, at(a, i, i_linear_order_n), 4'h0, d, 3'b010);
                repeat (ft ? 2 : 1) @(posedge i_clock);
                #2;
                check(o_dq, mem[at(a, i, i_linear_order_n)]);
                check(o_dq_oe, {4{!i_ninth_bit_on_n, 8'hff}});
            end
            host_u.cyc(3, 0, a, 4'h0, d, 3'b000);
            host_u.cyc(0, 0, a, 4'h0, d, 3'b010);
            #2 check(o_dq_oe, (ft && !sd) ? {4{!i_ninth_bit_on_n, 8'hff}} : 36'h0);
            host_u.cyc(0, 0, a, 4'h0, d, 3'b010);
            #2 check(o_dq_oe, 36'h0);
            $display("mode %0d done", md);
        end
        host_u.cyc(1, 0, a, 4'h0, d, 3'b010);
        i_sleep_request = 1'b1;
        repeat (3) @(posedge i_clock);
        #2 check(o_dq_oe, 36'h0);
        check({35'h0, o_sleeping}, 36'h1);
        check({35'h0, o_write_ready}, 36'h1);
        @(posedge i_clock);
        #1 i_strap_open = 4'h8;
        #2 check({35'h0, o_sleeping}, 36'h0);
        @(posedge i_clock);
        #1 i_drive_strength_sel = 1'b0;
        #2 check({35'h0, o_high_drive}, 36'h1);
        @(posedge i_clock);
        #1 i_strap_open = 4'hc;
        #2 check({35'h0, o_high_drive}, 36'h0);
        $display("straps done");
        print_verdict();
    end
endmodule
